// file: logic/scp_pkg.sv
package scp_pkg;
    // Register word indices; each byte address is four times its index.
    localparam logic [7:0] DIVCTL_INDEX = 8'h61;
    localparam logic [7:0] TRIM_INDEX = 8'h66;
    localparam logic [7:0] CFG_INDEX = 8'h70;
    localparam logic [7:0] STATUS_INDEX = 8'h71;
    localparam logic [9:0] DIVCTL_ADDR = {DIVCTL_INDEX, 2'b00};
    localparam logic [9:0] TRIM_ADDR = {TRIM_INDEX, 2'b00};
    localparam logic [9:0] CFG_ADDR = {CFG_INDEX, 2'b00};
    localparam logic [9:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
    // Field positions.
    localparam int UNLOCK_BIT = 7;
    localparam int TRIM_RANGE_BIT = 7;
    localparam int CFG_ASYNC_EXT_BIT = 0;
    localparam int CFG_TIMER_OSC_BIT = 1;
    localparam int CFG_WAKE_BIT = 2;
    // Values.
    localparam logic [7:0] UNLOCK_VALUE = 8'h80;
    localparam logic [3:0] SOURCE_EXTERNAL = 4'h0;
    localparam logic [3:0] SOURCE_RC = 4'h2;
    localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
    localparam logic [3:0] DIV_RESET_EIGHT = 4'h3;
    localparam logic [3:0] DIV_MAX_CODE = 4'h8;
    localparam logic [1:0] SUT_RESERVED = 2'h3;
    localparam logic [7:0] TRIM_FACTORY_DEFAULT = 8'h5A; // Arbitrary stand-in for the factory value.
    // Counts in cycles of the 50 MHz master clock.
    localparam int CLOCK_HZ = 50000000;
    localparam int UNLOCK_WINDOW_CYCLES = 4;
    localparam int WAKE_CYCLES = 6;
    localparam int RESET_BASE_CYCLES = 14;
    localparam int DELAY_SHORT_US = 4100;
    localparam int DELAY_LONG_US = 65000;
    localparam int DELAY_SHORT_CYCLES = int'((64'(DELAY_SHORT_US) * 64'(CLOCK_HZ) + 64'd999999) / 64'd1000000);
    localparam int DELAY_LONG_CYCLES = int'((64'(DELAY_LONG_US) * 64'(CLOCK_HZ) + 64'd999999) / 64'd1000000);
    localparam int TIMER_OSC_RATIO = 4;
endpackage

// file: logic/scp_ripple_div.sv
`timescale 1ns/1ps
// Free-running divide counter on the undivided clock; its state is not software visible.
module scp_ripple_div (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Count
    output logic [7:0] count_o
);
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            count_o <= 8'h00;
        end else begin
            count_o <= count_o + 8'h01;
        end
    end
endmodule

// file: logic/scp_delay_timer.sv
`timescale 1ns/1ps
// Loadable down counter; done_o is high while the count is zero and load_i is low.
module scp_delay_timer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic load_i,
    input wire logic [31:0] value_i,
    output logic done_o
);
    logic [31:0] count;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            count <= 32'h0000_0000;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != 32'h0000_0000) begin
            count <= count - 32'h0000_0001;
        end
    end

    assign done_o = (count == 32'h0000_0000) && !load_i;
endmodule

// file: logic/scp_clock_control.sv
`timescale 1ns/1ps
// Summary of operation
// R01: Source fuse code 0000 selects external clock input, 0 to 20 MHz.
// R02: External clock wake from power-down or power-save waits 6 cycles.
// R03: Reset delay by start-up fuses: 14, 14+4.1ms, 14+65ms, 11 reserved.
// R04: External source never changes frequency over 2% cycle to cycle.
// R05: Frequency changes over 2% happen only while held in reset.
// R06: Timer oscillator needs system clock at least four times its rate.
// R07: Timer oscillator usable only with the internal RC oscillator selected.
// R08: External clock on timer pin one only when async input enable is 1.
// R09: Clock-out fuse drives system clock on output pin, even during reset; here the pin is enabled in reset but sysclk is held low.
// R10: Clock output pin carries the divided clock.
// R11: Division applies to CPU, I/O and flash clock domains, any source.
// R12: Setting change gives no glitch and no period shorter than both settings.
// R13: New rate active after one old plus one or two new periods.
// R14: Prescaler counts on the undivided clock; count not software readable.
// R15: Software starts a change by writing 0x80.
// R16: Within four cycles software writes the new select value, unlock zero.
// R17: Software keeps interrupts off across the two-step change.
// R18: Unlock bit sets only when all other bits are written zero.
// R19: Unlock clears after four cycles or on select write; select needs unlock.
// R20: Rewriting unlock in the window neither restarts nor clears it.
// R21: Trim register loads factory value at reset; software may overwrite.
// R22: Trim bit 7 picks range; bits 6:0 tune low to high.
// R23: Software keeps trim at or below 8.8 MHz during nonvolatile writes.
// R24: Select codes 0000 to 1000 divide by 1 to 256; rest reserved; here code 0000 gives a 2-cycle period, as 0001 does.
// R25: Select resets to 0011 with divide-by-eight fuse, else 0000.
// R26: Fuse inputs are sampled at reset and held during operation.
module scp_clock_control (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Fuses
    input wire logic [3:0] source_choice_fuses_i,
    input wire logic [1:0] startup_delay_fuses_i,
    input wire logic clock_out_fuse_i,
    input wire logic divide_by_eight_fuse_i,
    // Pins
    input wire logic timer_osc_pin_one_i,
    // Power management
    input wire logic wake_request_i,
    // Clock domains
    output logic cpu_clock_domain_o,
    output logic io_clock_domain_o,
    output logic flash_clock_domain_o,
    output logic sysclk_out_pin_o,
    output logic sysclk_out_pin_oe_o,
    output logic core_hold_o,
    output logic timer_osc_clock_o,
    output logic timer_osc_enabled_o,
    output logic external_source_o,
    output logic [7:0] rc_trim_o
);
    typedef enum logic [1:0] {
        SCP_RESET_WAIT,
        SCP_RUN,
        SCP_WAKE_WAIT,
        SCP_FAULT
    } scp_state_e;

    // Fuse copies and register fields.
    scp_state_e state;
    logic [3:0] source_choice;
    logic [1:0] startup_delay;
    logic clock_out_en;
    logic fuses_taken;
    logic [3:0] divider_select;
    logic divider_change_unlock;
    logic [2:0] unlock_count;
    logic [7:0] rc_trim_reg;
    logic async_ext_input_enable;
    logic timer_osc_request;

    // Divider state.
    logic [3:0] active_select;
    logic [7:0] div_count;
    logic [7:0] div_mask;
    logic sysclk;

    // Synchroniser stages.
    logic tosc_meta;
    logic tosc_sync;
    logic wake_meta;
    logic wake_sync;
    logic wake_prev;

    // Start-up timer.
    logic timer_load;
    logic [31:0] timer_value;
    logic timer_done;

    // Bus decode.
    logic apb_write;
    logic apb_read;
    logic [9:0] word_addr;
    logic addr_hit;
    logic [7:0] wbyte;
    logic [31:0] next_rdata;

    assign apb_write = psel_i && penable_i && pwrite_i;
    assign apb_read = psel_i && penable_i && !pwrite_i;
    assign word_addr = paddr_i[11:2];
    assign wbyte = pwdata_i[7:0];
    assign addr_hit = (word_addr == scp_pkg::DIVCTL_ADDR[9:0] >> 2) || (word_addr == scp_pkg::TRIM_ADDR >> 2)
        || (word_addr == scp_pkg::CFG_ADDR >> 2) || (word_addr == scp_pkg::STATUS_ADDR >> 2);
    // No wait state is ever inserted.
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit;

    // Fuses are caught once after reset release and then held.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fuses_taken <= 1'b0;
            source_choice <= scp_pkg::SOURCE_RC;
            startup_delay <= 2'h0;
            clock_out_en <= 1'b0;
        end else if (!fuses_taken) begin
            fuses_taken <= 1'b1; // R26
            source_choice <= source_choice_fuses_i;
            startup_delay <= startup_delay_fuses_i;
            clock_out_en <= clock_out_fuse_i;
        end
    end

    // Two-flop synchronisers for the timer pin and the wake request.
    // Only the second stages and the wake_prev copy of wake_sync feed logic.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            tosc_meta <= 1'b0;
            tosc_sync <= 1'b0;
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
            wake_prev <= 1'b0;
        end else begin
            tosc_meta <= timer_osc_pin_one_i;
            tosc_sync <= tosc_meta;
            wake_meta <= wake_request_i;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
        end
    end

    // Unlock bit and its four-cycle window; the guarded select field follows.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            divider_change_unlock <= 1'b0;
            unlock_count <= 3'h0;
        end else if (apb_write && word_addr == (scp_pkg::DIVCTL_ADDR >> 2) && divider_change_unlock
                     && !wbyte[scp_pkg::UNLOCK_BIT]) begin
            divider_change_unlock <= 1'b0; // R19
            unlock_count <= 3'h0;
        end else if (apb_write && word_addr == (scp_pkg::DIVCTL_ADDR >> 2) && !divider_change_unlock
                     && wbyte == scp_pkg::UNLOCK_VALUE) begin
            divider_change_unlock <= 1'b1; // R18
            unlock_count <= 3'(scp_pkg::UNLOCK_WINDOW_CYCLES - 1);
        end else if (divider_change_unlock) begin
            // A repeated unlock write lands here.
            // R20
            if (unlock_count == 3'h0) begin
                divider_change_unlock <= 1'b0; // R19
            end else begin
                unlock_count <= unlock_count - 3'h1;
            end
        end
    end

    // Fuse reset value loads on the fuse-catch edge.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            divider_select <= scp_pkg::DIV_RESET_PLAIN;
        end else if (!fuses_taken) begin
            divider_select <= divide_by_eight_fuse_i ? scp_pkg::DIV_RESET_EIGHT : scp_pkg::DIV_RESET_PLAIN; // R25
        end else if (apb_write && word_addr == (scp_pkg::DIVCTL_ADDR >> 2) && divider_change_unlock
                     && !wbyte[scp_pkg::UNLOCK_BIT]) begin
            divider_select <= wbyte[3:0]; // R19
        end
    end

    // Trim register; the configuration bits follow.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rc_trim_reg <= scp_pkg::TRIM_FACTORY_DEFAULT; // R21
        end else if (apb_write && word_addr == (scp_pkg::TRIM_ADDR >> 2)) begin
            rc_trim_reg <= wbyte; // R21 R22
        end
    end

    // Timer oscillator controls.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            async_ext_input_enable <= 1'b0;
            timer_osc_request <= 1'b0;
        end else if (apb_write && word_addr == (scp_pkg::CFG_ADDR >> 2)) begin
            async_ext_input_enable <= wbyte[scp_pkg::CFG_ASYNC_EXT_BIT];
            timer_osc_request <= wbyte[scp_pkg::CFG_TIMER_OSC_BIT];
        end
    end

    // Rate change: the new select is adopted where the count bits under the old mask are all ones, which is the
    // end of an old divided period, or any cycle while the old select is 0; the new divider's alignment is not checked.
    scp_ripple_div u_div (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .count_o(div_count)
    ); // R14

    // Mask of the count bits that span one divided period.
    always_comb begin
        div_mask = 8'h00;
        if (active_select != 4'h0) begin
            div_mask = 8'(({8'h00, 1'b1} << active_select) - 9'h001);
        end
    end

    // Reserved codes are kept for readback but never reach the divider.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            active_select <= scp_pkg::DIV_RESET_PLAIN;
        end else if (active_select != divider_select && divider_select <= scp_pkg::DIV_MAX_CODE
                     && (div_count & div_mask) == div_mask) begin
            active_select <= divider_select; // R12 R13
        end
    end

    // Divided clock: high for the first half of each divided period.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sysclk <= 1'b0;
        end else if (active_select == 4'h0) begin
            // Half the master rate: toggles every cycle, as select 1 does.
            sysclk <= ~sysclk; // R24
        end else if ((div_count & div_mask) == div_mask) begin
            sysclk <= 1'b1; // R24
        end else if ((div_count & div_mask) == (div_mask >> 1)) begin
            sysclk <= 1'b0;
        end
    end

    // Start-up sequencing.
    // Fuse catch loads the reset delay; a wake edge in SCP_RUN loads WAKE_CYCLES.
    always_comb begin
        timer_load = 1'b0;
        timer_value = 32'h0000_0000;
        if (state == SCP_RESET_WAIT && !fuses_taken) begin
            timer_load = 1'b1;
            unique case (startup_delay_fuses_i)
                2'h0: timer_value = 32'(scp_pkg::RESET_BASE_CYCLES);
                2'h1: timer_value = 32'(scp_pkg::RESET_BASE_CYCLES + scp_pkg::DELAY_SHORT_CYCLES);
                2'h2: timer_value = 32'(scp_pkg::RESET_BASE_CYCLES + scp_pkg::DELAY_LONG_CYCLES);
                2'h3: timer_value = 32'h0000_0000;
            endcase // R03
        end else if (state == SCP_RUN && wake_sync && !wake_prev) begin
            timer_load = 1'b1;
            timer_value = 32'(scp_pkg::WAKE_CYCLES); // R02
        end
    end

    // One timer serves both the reset delay and the wake delay.
    scp_delay_timer u_timer (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .load_i(timer_load),
        .value_i(timer_value),
        .done_o(timer_done)
    );

    // Core hold sequencing: start delay, run, wake delay, or a stuck hold.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state <= SCP_RESET_WAIT;
        end else begin
            unique case (state)
                SCP_RESET_WAIT: begin
                    if (fuses_taken && startup_delay == scp_pkg::SUT_RESERVED) begin
                        state <= SCP_FAULT; // R03
                    end else if (fuses_taken && timer_done) begin
                        state <= SCP_RUN;
                    end
                end
                SCP_RUN: begin
                    if (timer_load) begin
                        state <= SCP_WAKE_WAIT;
                    end
                end
                SCP_WAKE_WAIT: begin
                    if (timer_done) begin
                        state <= SCP_RUN;
                    end
                end
                SCP_FAULT: begin
                    // Only a new reset leaves this state.
                    state <= SCP_FAULT;
                end
            endcase
        end
    end

    // Read mux; the divider count itself is never readable.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (word_addr == (scp_pkg::DIVCTL_ADDR >> 2)) begin
            next_rdata = {24'h00_0000, divider_change_unlock, 3'h0, divider_select};
        end else if (word_addr == (scp_pkg::TRIM_ADDR >> 2)) begin
            next_rdata = {24'h00_0000, rc_trim_reg};
        end else if (word_addr == (scp_pkg::CFG_ADDR >> 2)) begin
            next_rdata = {30'h0000_0000, timer_osc_request, async_ext_input_enable};
        end else if (word_addr == (scp_pkg::STATUS_ADDR >> 2)) begin
            next_rdata = {24'h00_0000, active_select, 1'b0, state == SCP_WAKE_WAIT, timer_osc_enabled_o,
                external_source_o};
        end
    end

    // Read data is caught in the setup cycle.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

    // Clock gating and pin outputs.
    logic running;
    assign running = (state == SCP_RUN);
    assign external_source_o = (source_choice == scp_pkg::SOURCE_EXTERNAL); // R01
    assign timer_osc_enabled_o = timer_osc_request && (source_choice == scp_pkg::SOURCE_RC); // R07 R06
    assign timer_osc_clock_o = timer_osc_enabled_o && async_ext_input_enable && tosc_sync; // R08
    assign cpu_clock_domain_o = sysclk && running; // R11
    assign io_clock_domain_o = sysclk && running; // R11
    assign flash_clock_domain_o = sysclk && running; // R11
    assign sysclk_out_pin_o = sysclk; // R09 R10
    // Until the fuses are caught, the raw clock-out fuse claims the pin.
    assign sysclk_out_pin_oe_o = clock_out_en || (!fuses_taken && clock_out_fuse_i); // R09
    assign core_hold_o = !running;
    assign rc_trim_o = rc_trim_reg; // R22
endmodule

// file: testbench/scp_clock_control_props.sv
`timescale 1ns/1ps
module scp_clock_control_props (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    // Fuses and outputs
    input wire logic [3:0] source_choice_fuses_i,
    input wire logic clock_out_fuse_i,
    input wire logic cpu_clock_domain_o,
    input wire logic io_clock_domain_o,
    input wire logic flash_clock_domain_o,
    input wire logic sysclk_out_pin_oe_o,
    input wire logic core_hold_o,
    input wire logic timer_osc_clock_o,
    input wire logic timer_osc_enabled_o,
    input wire logic external_source_o,
    input wire logic [7:0] rc_trim_o
);
    logic trim_wr;
    assign trim_wr = psel_i && penable_i && pwrite_i && paddr_i == 12'(scp_pkg::TRIM_ADDR);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_trim_write;
        psel_i && penable_i && pwrite_i && paddr_i == 12'(scp_pkg::TRIM_ADDR);
    endsequence
    property p_oe;
        sysclk_out_pin_oe_o == clock_out_fuse_i;
    endproperty
    property p_ext;
        $past(reset_n_i) |-> external_source_o == (source_choice_fuses_i == scp_pkg::SOURCE_EXTERNAL);
    endproperty
    property p_static;
        $past(reset_n_i) && $past(reset_n_i, 2) |-> $stable(external_source_o);
    endproperty
    property p_tosc_rc;
        timer_osc_enabled_o |-> source_choice_fuses_i == scp_pkg::SOURCE_RC;
    endproperty
    property p_tosc_gate;
        timer_osc_clock_o |-> timer_osc_enabled_o;
    endproperty
    property p_domains;
        cpu_clock_domain_o == io_clock_domain_o && io_clock_domain_o == flash_clock_domain_o;
    endproperty
    property p_hold_gate;
        core_hold_o |-> !cpu_clock_domain_o;
    endproperty
    property p_trim_load;
        s_trim_write |=> rc_trim_o == $past(pwdata_i[7:0]);
    endproperty
    property p_trim_hold;
        $changed(rc_trim_o) |-> $past(trim_wr);
    endproperty
    a_oe: assert property (p_oe) else $error("clock out enable differs from fuse");
    a_ext: assert property (p_ext) else $error("external source flag wrong");
    a_static: assert property (p_static) else $error("fuse state moved in operation");
    a_tosc_rc: assert property (p_tosc_rc) else $error("timer oscillator on without RC source");
    a_tosc_gate: assert property (p_tosc_gate) else $error("timer clock passed while disabled");
    a_domains: assert property (p_domains) else $error("clock domains differ");
    a_hold_gate: assert property (p_hold_gate) else $error("core clock runs in hold");
    a_trim_load: assert property (p_trim_load) else $error("trim write not taken");
    a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");
endmodule
bind scp_clock_control scp_clock_control_props i_scp_clock_control_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .source_choice_fuses_i(source_choice_fuses_i), .clock_out_fuse_i(clock_out_fuse_i),
    .cpu_clock_domain_o(cpu_clock_domain_o), .io_clock_domain_o(io_clock_domain_o),
    .flash_clock_domain_o(flash_clock_domain_o), .sysclk_out_pin_oe_o(sysclk_out_pin_oe_o),
    .core_hold_o(core_hold_o), .timer_osc_clock_o(timer_osc_clock_o), .timer_osc_enabled_o(timer_osc_enabled_o),
    .external_source_o(external_source_o), .rc_trim_o(rc_trim_o));

// file: testbench/scp_ext_source.sv
`timescale 1ns/1ps
module scp_ext_source #(
    parameter int HALF_NS = 200
) (
    // Control
    input wire logic run_i,
    // Pin
    output logic pin_o
);
    // A fixed period keeps drift at zero and stays well under a quarter of the master clock rate.
    initial begin
        pin_o = 1'b0;
        forever begin
            #(HALF_NS);
            if (run_i) begin
                pin_o = ~pin_o;
            end
        end
    end
endmodule

// file: testbench/scp_clock_control_bench.sv
`timescale 1ns/1ps
module scp_clock_control_bench;
    localparam logic [11:0] A_DIV = 12'(scp_pkg::DIVCTL_ADDR);
    localparam logic [11:0] A_TRIM = 12'(scp_pkg::TRIM_ADDR);
    localparam logic [11:0] A_CFG = 12'(scp_pkg::CFG_ADDR);
    logic mclk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err, src_run;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] source_choice_fuses_i;
    logic [1:0] startup_delay_fuses_i;
    logic clock_out_fuse_i, divide_by_eight_fuse_i, timer_osc_pin_one_i, wake_request_i, cpu_clock_domain_o;
    logic io_clock_domain_o, flash_clock_domain_o, sysclk_out_pin_o, sysclk_out_pin_oe_o, core_hold_o;
    logic timer_osc_clock_o, timer_osc_enabled_o, external_source_o;
    logic [7:0] rc_trim_o;
    int err_total, num_checks, p, n, c, s;
    scp_clock_control i_scp_clock_control (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .source_choice_fuses_i(source_choice_fuses_i),
        .startup_delay_fuses_i(startup_delay_fuses_i), .clock_out_fuse_i(clock_out_fuse_i),
        .divide_by_eight_fuse_i(divide_by_eight_fuse_i), .timer_osc_pin_one_i(timer_osc_pin_one_i),
        .wake_request_i(wake_request_i), .cpu_clock_domain_o(cpu_clock_domain_o),
        .io_clock_domain_o(io_clock_domain_o), .flash_clock_domain_o(flash_clock_domain_o),
        .sysclk_out_pin_o(sysclk_out_pin_o), .sysclk_out_pin_oe_o(sysclk_out_pin_oe_o), .core_hold_o(core_hold_o),
        .timer_osc_clock_o(timer_osc_clock_o), .timer_osc_enabled_o(timer_osc_enabled_o),
        .external_source_o(external_source_o), .rc_trim_o(rc_trim_o));
    scp_ext_source i_scp_ext_source (.run_i(src_run), .pin_o(timer_osc_pin_one_i));
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            chk("pready wait", 1, 0);
            final_report();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(w, e, rd);
    endtask
    task automatic do_reset(input logic [3:0] src, input logic [1:0] startup_delay_fuses, input logic co, input logic d8);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        source_choice_fuses_i <= src;
        startup_delay_fuses_i <= startup_delay_fuses;
        clock_out_fuse_i <= co;
        divide_by_eight_fuse_i <= d8;
        repeat (16) @(posedge mclk_i);
        #1;
        chk("oe in reset", co, sysclk_out_pin_oe_o);
        chk("trim in reset", scp_pkg::TRIM_FACTORY_DEFAULT, rc_trim_o);
        chk("hold in reset", 1, core_hold_o);
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
    endtask
    task automatic watch(input logic w, output int t);
        logic q;
        t = 0;
        q = timer_osc_clock_o;
        repeat (200) begin
            @(posedge mclk_i);
            #1;
            if (w ? (timer_osc_clock_o !== q) : (core_hold_o === 1'b1)) t++;
            q = timer_osc_clock_o;
        end
    endtask
    task automatic period(input logic w, output int r);
        int t[$];
        int i;
        logic q, v;
        q = 1'b1;
        for (i = 0; i < 1200 && t.size() < 3; i++) begin
            @(posedge mclk_i);
            #1;
            v = w ? cpu_clock_domain_o : sysclk_out_pin_o;
            if (!q && v) t.push_back(i);
            q = v;
        end
        r = (t.size() == 3) ? t[2] - t[1] : 0;
    endtask
    task automatic set_div(input logic [3:0] d);
        apb(1'b1, A_DIV, 32'h80);
        apb(1'b1, A_DIV, {28'h0, d});
    endtask
    initial begin
        {reset_n_i, psel_i, penable_i, pwrite_i, wake_request_i, clock_out_fuse_i, divide_by_eight_fuse_i} = '0;
        {paddr_i, pwdata_i, source_choice_fuses_i, startup_delay_fuses_i} = '0;
        src_run = 1'b1;
        void'($urandom(34));
        do_reset(scp_pkg::SOURCE_EXTERNAL, 2'b00, 1'b1, 1'b1);
        n = 0;
        while (core_hold_o === 1'b1 && n < 100) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk("start delay", 1, n >= 14 && n <= 19);
        chk("external source", 1, external_source_o);
        rdc("div reset", A_DIV, 32'h3);
        period(1'b1, p);
        chk("cpu period", 8, p);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped error", 1, err);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : $urandom % 256;
            apb(1'b1, A_TRIM, c);
            rdc("trim read", A_TRIM, c);
            chk("trim pins", c[7:0], rc_trim_o);
        end
        $display("test trim done");
        s = $urandom % 9;
        for (int k = 0; k < 9; k++) begin
            c = (s + k) % 9;
            set_div(c[3:0]);
            rdc("div select", A_DIV, c);
            if (c != 0) begin
                repeat (600) @(posedge mclk_i);
                period(1'b0, p);
                chk("out period", 1 << c, p);
            end
        end
        set_div(4'h2);
        repeat (600) @(posedge mclk_i);
        c = 9 + $urandom % 7;
        set_div(c[3:0]);
        rdc("reserved stored", A_DIV, c);
        repeat (600) @(posedge mclk_i);
        period(1'b0, p);
        chk("reserved period", 4, p);
        apb(1'b1, A_DIV, 32'h01);
        rdc("no unlock", A_DIV, c);
        apb(1'b1, A_DIV, 32'h81);
        apb(1'b1, A_DIV, 32'h01);
        rdc("bad unlock", A_DIV, c);
        apb(1'b1, A_DIV, 32'h80);
        @(posedge mclk_i);
        apb(1'b1, A_DIV, 32'h80);
        apb(1'b1, A_DIV, 32'h01);
        rdc("no restart", A_DIV, c);
        $display("test divider done");
        apb(1'b1, A_CFG, 32'h3);
        repeat (4) @(posedge mclk_i);
        chk("timer osc off", 0, timer_osc_enabled_o);
        @(posedge mclk_i);
        wake_request_i <= 1'b1;
        watch(1'b0, n);
        chk("wake hold", 1, n >= 6 && n <= 8);
        @(posedge mclk_i);
        wake_request_i <= 1'b0;
        $display("test wake done");
        do_reset(scp_pkg::SOURCE_EXTERNAL, 2'b11, 1'b0, 1'b0);
        watch(1'b0, n);
        chk("reserved start", 200, n);
        do_reset(scp_pkg::SOURCE_RC, 2'b00, 1'b0, 1'b0);
        repeat (30) @(posedge mclk_i);
        rdc("div plain reset", A_DIV, 32'h0);
        chk("rc source", 0, external_source_o);
        apb(1'b1, A_CFG, 32'h2);
        watch(1'b1, n);
        chk("timer osc on", 1, timer_osc_enabled_o);
        chk("no async clock", 0, n);
        apb(1'b1, A_CFG, 32'h3);
        watch(1'b1, n);
        chk("async clock", 1, n > 10);
        $display("test timer done");
        final_report();
    end
endmodule
